// *** rtl/ssp_pkg.sv ***
// Shared types and constants of the serial register port
package ssp_pkg;

  // ----------------------------------------------------------------
  // Addressing and framing
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_FIXED = 4'h3;
  localparam int STRAP_W = 3;
  localparam int PTR_W = 8;
  localparam int REG_W = 16;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] BYTE_PTR = 2'h0;
  localparam logic [1:0] BYTE_MSB = 2'h1;
  localparam logic [1:0] BYTE_LSB = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BUS_TIMEOUT_US = 30000;
  localparam longint LINK_CLK_KHZ = 166667;
  localparam int TIMEOUT_CYC =
    int'((longint'(BUS_TIMEOUT_US) * LINK_CLK_KHZ) / 1000);
  localparam int TMO_W = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AWAIT,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_TXEND,
    ST_TXACK,
    ST_IGNORE
  } ssp_state_e;

  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [REG_W-1:0] data;
  } ssp_wr_s;

endpackage : ssp_pkg

// *** rtl/ssp_pair_buf.sv ***
// Small shift-register FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ssp_pair_buf #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] wr_idx;
  logic vld_r;
  logic push;
  logic pop;

  assign o_ready = cnt_r < CW'(DEPTH);
  assign push = i_valid && o_ready;
  assign pop = vld_r && i_ready;
  assign wr_idx = pop ? cnt_r - CW'(1) : cnt_r;
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  assign o_valid = vld_r;
  assign o_data = mem_r[0];

  // Head always sits in entry 0, so the drain side sees a flop
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (push && i == int'(wr_idx)) begin
        mem_r[i] <= i_data;
      end else if (pop && i < DEPTH - 1) begin
        mem_r[i] <= mem_r[i+1];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
      vld_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      vld_r <= cnt_nxt != '0;
    end
  end

  no_overflow_a : assert property (@(posedge i_clk) disable iff (i_rst)
    cnt_r <= CW'(DEPTH)) else $error("buffer count above depth");

endmodule : ssp_pair_buf

// *** rtl/ssp_port.sv ***
// Two-wire slave register port: link engine and register-side crossing
// What this block does
// - SDA falling while SCL high is start
// - SDA rising while SCL high is stop
// - Start mid-transfer restarts the bus machine
// - Stop while transmitting releases SDA, goes idle
// - Acknowledge only address 0011 plus strap pins
// - Eighth address bit: one reads, zero writes
// - Acknowledge every received byte while receiver
// - Master NAK ends read; SDA stays released
// - No auto-increment; one register per access
// - Pointer kept for later pointer-less reads
// - SCL stuck past timeout resets the interface
// - Data changes only while SCL is low
// - Both lines high, no transfer, is idle
// - Slave only; never drives SCL
`timescale 1ns/1ps
module ssp_port
  import ssp_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int BUF_DEPTH = 2
) (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_link_clk,
  // Serial pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [STRAP_W-1:0] i_addr_strap,
  // Register write stream
  output logic o_wr_valid,
  output ssp_wr_s o_wr_word,
  input wire logic i_wr_ready,
  // Register read lookup
  output logic [PTR_W-1:0] o_rd_ptr,
  input wire logic [REG_W-1:0] i_rd_data
);

  // ----------------------------------------------------------------
  // Link domain: synchronisers
  // ----------------------------------------------------------------
  logic link_rst_m_r;
  logic link_rst_r;
  logic scl_m_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_d_r;
  logic [STRAP_W-1:0] strap_m_r;
  logic [STRAP_W-1:0] strap_s_r;

  always_ff @(posedge i_link_clk) begin
    link_rst_m_r <= i_rst;
    link_rst_r <= link_rst_m_r;
    scl_m_r <= i_scl;
    scl_s_r <= scl_m_r;
    scl_d_r <= scl_s_r;
    sda_m_r <= i_sda;
    sda_s_r <= sda_m_r;
    sda_d_r <= sda_s_r;
    strap_m_r <= i_addr_strap;
    strap_s_r <= strap_m_r;
  end

  // ----------------------------------------------------------------
  // Link domain: bus events
  // ----------------------------------------------------------------
  wire scl_rise = scl_s_r && !scl_d_r;
  wire scl_fall = !scl_s_r && scl_d_r;
  wire scl_hold = scl_s_r && scl_d_r;
  wire start_ev = scl_hold && sda_d_r && !sda_s_r;
  wire stop_ev = scl_hold && !sda_d_r && sda_s_r;

  ssp_state_e st_r, st_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic ack_r, ack_nxt;
  logic rw_r, rw_nxt;
  logic lsb_r, lsb_nxt;
  logic [1:0] bcnt_r, bcnt_nxt;
  logic [PTR_W-1:0] ptr_r, ptr_nxt;
  logic [7:0] msb_r, msb_nxt;
  ssp_wr_s wr_word_r, wr_word_nxt;
  logic wr_tgl_r, wr_tgl_nxt;
  logic rd_tgl_r, rd_tgl_nxt;
  logic oe_r, oe_nxt;
  logic sda_o_r;
  logic [TMO_W-1:0] tmo_cnt_r;
  logic [REG_W-1:0] rd_data_r;

  wire [7:0] byte_in = {sh_r[6:0], sda_s_r};
  wire addr_hit = byte_in[7:1] == {ADDR_FIXED, strap_s_r};
  wire [7:0] tx_byte = lsb_r ? rd_data_r[7:0] : rd_data_r[15:8];
  wire byte_done = scl_rise && bit_r == BIT_LAST;
  wire ptr_load = st_r == ST_RX && byte_done && bcnt_r == BYTE_PTR;
  wire tmo_ev = tmo_cnt_r == TMO_W'(TIMEOUT_CYCLES - 1);
  // Any state but ST_IDLE can time out, ST_IGNORE included; an idle bus is normal
  wire tmo_clr = st_r == ST_IDLE || scl_s_r != scl_d_r || tmo_ev;

  // ----------------------------------------------------------------
  // Link domain: bus machine
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ack_nxt = ack_r;
    rw_nxt = rw_r;
    lsb_nxt = lsb_r;
    bcnt_nxt = bcnt_r;
    ptr_nxt = ptr_r;
    msb_nxt = msb_r;
    wr_word_nxt = wr_word_r;
    wr_tgl_nxt = wr_tgl_r;
    rd_tgl_nxt = rd_tgl_r;
    oe_nxt = oe_r;
    if (tmo_ev || stop_ev) begin
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else if (start_ev) begin
      st_nxt = ST_ADDR;
      bit_nxt = '0;
      oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE, ST_IGNORE: begin
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_nxt = byte_in;
            bit_nxt = bit_r + 3'h1;
          end
          if (byte_done) begin
            st_nxt = ST_AWAIT;
            if (st_r == ST_ADDR) begin
              ack_nxt = addr_hit;
              rw_nxt = sda_s_r;
              lsb_nxt = 1'b0;
              bcnt_nxt = BYTE_PTR;
              // Fetch early so the word is ready before the ack ends
              if (addr_hit && sda_s_r) begin
                rd_tgl_nxt = !rd_tgl_r;
              end
            end else begin
              ack_nxt = 1'b1;
              unique case (bcnt_r)
                BYTE_PTR: begin
                  ptr_nxt = byte_in;
                  bcnt_nxt = BYTE_MSB;
                end
                BYTE_MSB: begin
                  msb_nxt = byte_in;
                  bcnt_nxt = BYTE_LSB;
                end
                default: begin
                  // Pointer is not advanced between words
                  wr_word_nxt = '{ptr: ptr_r, data: {msb_r, byte_in}};
                  wr_tgl_nxt = !wr_tgl_r;
                  bcnt_nxt = BYTE_MSB;
                end
              endcase
            end
          end
        end
        ST_AWAIT: begin
          if (scl_fall) begin
            oe_nxt = ack_r;
            st_nxt = ack_r ? ST_ACK : ST_IGNORE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_nxt = '0;
            if (rw_r) begin
              sh_nxt = tx_byte;
              oe_nxt = !tx_byte[7];
              st_nxt = ST_TX;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], 1'b1};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == BIT_LAST) begin
              st_nxt = ST_TXEND;
            end
          end else if (scl_fall) begin
            oe_nxt = !sh_r[7];
          end
        end
        ST_TXEND: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            st_nxt = ST_TXACK;
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            // Master drives this bit; a NAK or a third byte parks us
            if (!sda_s_r && !lsb_r) begin
              lsb_nxt = 1'b1;
              st_nxt = ST_ACK;
            end else begin
              st_nxt = ST_IGNORE;
            end
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (link_rst_r) begin
      st_r <= ST_IDLE;
      oe_r <= 1'b0;
      tmo_cnt_r <= '0;
      wr_tgl_r <= 1'b0;
      rd_tgl_r <= 1'b0;
      ptr_r <= '0;
    end else begin
      st_r <= st_nxt;
      oe_r <= oe_nxt;
      tmo_cnt_r <= tmo_clr ? '0 : tmo_cnt_r + TMO_W'(1);
      wr_tgl_r <= wr_tgl_nxt;
      rd_tgl_r <= rd_tgl_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (link_rst_r) begin
      bit_r <= '0;
      sh_r <= '0;
      ack_r <= 1'b0;
      rw_r <= 1'b0;
      lsb_r <= 1'b0;
      bcnt_r <= BYTE_PTR;
      msb_r <= '0;
      wr_word_r <= '0;
      sda_o_r <= 1'b0;
    end else begin
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ack_r <= ack_nxt;
      rw_r <= rw_nxt;
      lsb_r <= lsb_nxt;
      bcnt_r <= bcnt_nxt;
      msb_r <= msb_nxt;
      wr_word_r <= wr_word_nxt;
      sda_o_r <= 1'b0;
    end
  end

  // SCL is only ever sampled; the port has no clock driver at all
  assign o_sda_o = sda_o_r;
  assign o_sda_oe = oe_r;

  // ----------------------------------------------------------------
  // Register domain: crossings
  // ----------------------------------------------------------------
  logic wt_m_r;
  logic wt_s_r;
  logic wt_seen_r;
  logic rt_m_r;
  logic rt_s_r;
  logic rt_seen_r;
  logic rd_cap_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic buf_ready;

  // Link words stay frozen until the next toggle, so sampling is safe
  wire wr_pend = wt_s_r != wt_seen_r;
  wire wr_push = wr_pend && buf_ready;
  wire rd_pend = rt_s_r != rt_seen_r;

  always_ff @(posedge i_clk) begin
    wt_m_r <= wr_tgl_r;
    wt_s_r <= wt_m_r;
    rt_m_r <= rd_tgl_r;
    rt_s_r <= rt_m_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wt_seen_r <= 1'b0;
      rt_seen_r <= 1'b0;
      rd_cap_r <= 1'b0;
      rd_ptr_r <= '0;
      rd_data_r <= '0;
    end else begin
      if (wr_push) begin
        wt_seen_r <= wt_s_r;
      end
      if (rd_pend) begin
        rt_seen_r <= rt_s_r;
        rd_ptr_r <= ptr_r;
      end
      rd_cap_r <= rd_pend;
      if (rd_cap_r) begin
        rd_data_r <= i_rd_data;
      end
    end
  end

  assign o_rd_ptr = rd_ptr_r;

  ssp_pair_buf #(
    .WIDTH($bits(ssp_wr_s)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(wr_pend),
    .i_data(wr_word_r),
    .o_ready(buf_ready),
    .o_valid(o_wr_valid),
    .o_data(o_wr_word),
    .i_ready(i_wr_ready)
  );

  // ----------------------------------------------------------------
  // Checks on the link engine
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_link_clk); endclocking
  default disable iff (link_rst_r);

  sequence s_nak_seen;
    st_r == ST_TXACK && scl_rise && sda_s_r && !tmo_ev && !start_ev;
  endsequence

  sequence s_parked;
    st_r == ST_IGNORE && !oe_r;
  endsequence

  start_abort_a : assert property (start_ev && !tmo_ev && !stop_ev
    |=> st_r == ST_ADDR && !oe_r)
    else $error("start did not restart the machine");
  stop_idle_a : assert property (stop_ev |=> st_r == ST_IDLE && !oe_r)
    else $error("stop left the data line driven");
  addr_nak_a : assert property (st_r == ST_AWAIT && !ack_r && scl_fall
    && !start_ev && !tmo_ev |=> !oe_r [*2])
    else $error("foreign address was acknowledged");
  recv_ack_a : assert property (st_r == ST_AWAIT && ack_r && scl_fall
    && !tmo_ev |=> oe_r && st_r == ST_ACK)
    else $error("received byte not acknowledged");
  nak_release_a : assert property (s_nak_seen |=> s_parked)
    else $error("data line not released after master nak");
  sda_hold_a : assert property (scl_hold && !$past(start_ev)
    && !$past(stop_ev) && !$past(tmo_ev) |-> $stable(oe_r))
    else $error("data moved while clock high");
  timeout_rst_a : assert property (tmo_ev |=> st_r == ST_IDLE && !oe_r
    && tmo_cnt_r == '0)
    else $error("stuck clock did not reset the interface");
  idle_free_a : assert property (st_r == ST_IDLE |-> !oe_r)
    else $error("idle bus is being driven");
  ptr_keep_a : assert property (!ptr_load |=> $stable(ptr_r))
    else $error("pointer changed without a pointer byte");
  pair_emit_a : assert property ($changed(wr_tgl_r)
    |-> $past(bcnt_r) == BYTE_LSB && st_r == ST_AWAIT)
    else $error("write word emitted off the byte pair");
  tx_dir_a : assert property (st_r == ST_ACK && scl_fall && rw_r
    && !start_ev && !stop_ev && !tmo_ev |=> st_r == ST_TX)
    else $error("read direction did not start transmit");

endmodule : ssp_port

// *** dv/ssp_master.sv ***
// Behavioural two-wire bus master that drives the port's serial pins
`timescale 1ns/1ps
module ssp_master (
  // Bench clock paces the bus
  input wire logic i_clk,
  // Serial lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Quarter bit: each level stays far longer than the sync delay
  task automatic qw();
    repeat (6) @(negedge i_clk);
  endtask : qw

  task automatic start();
    o_sda_low = 1'b0;
    qw();
    o_scl = 1'b1;
    qw();
    o_sda_low = 1'b1;
    qw();
    o_scl = 1'b0;
  endtask : start

  task automatic stop();
    o_sda_low = 1'b1;
    qw();
    o_scl = 1'b1;
    qw();
    o_sda_low = 1'b0;
    repeat (4) qw();
  endtask : stop

  // Data moves a quarter away from either clock edge
  task automatic xbit(input logic b, output logic r);
    o_sda_low = ~b;
    qw();
    o_scl = 1'b1;
    qw();
    r = i_sda;
    qw();
    o_scl = 1'b0;
    qw();
  endtask : xbit

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, ack);
  endtask : wbyte

  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(nak, r);
  endtask : rbyte
endmodule : ssp_master

// *** dv/testbench.sv ***
// Self-checking bench of the serial register port
`timescale 1ns/1ps
module testbench;
  import ssp_pkg::*;
  localparam logic [7:0] ADDR_W = {ADDR_FIXED, 3'h5, 1'b0};
  localparam logic [7:0] ADDR_R = {ADDR_FIXED, 3'h5, 1'b1};
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic rdy = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl, sda_low, sda_o, sda_oe, wr_valid;
  ssp_wr_s wr_word;
  logic [PTR_W-1:0] rd_ptr;
  // Open-drain data line with pull-up
  wire logic sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
  wire logic [REG_W-1:0] rd_data = {rd_ptr, ~rd_ptr};
  int err_total = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;
  always #3 lclk = ~lclk;

  ssp_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));

  // Short timeout keeps the stuck-clock test brief
  ssp_port #(.TIMEOUT_CYCLES(200)) dut (.i_clk(clk), .i_rst(rst),
    .i_link_clk(lclk), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_addr_strap(strap), .o_wr_valid(wr_valid),
    .o_wr_word(wr_word), .i_wr_ready(rdy), .o_rd_ptr(rd_ptr),
    .i_rd_data(rd_data));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    m.wbyte(d, a);
    chk("ack", {23'h0, exp_ack}, {23'h0, a});
  endtask : send

  task automatic pop(input logic [23:0] exp);
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("valid", 24'h1, {23'h0, wr_valid});
    chk("word", exp, wr_word);
    rdy = 1'b1;
    @(negedge clk);
    rdy = 1'b0;
    // Let an edge pass so a second pop never re-raises ready at once
    @(negedge clk);
  endtask : pop

  task automatic read2(input logic [15:0] exp);
    logic [7:0] hi, lo;
    m.rbyte(1'b0, hi);
    m.rbyte(1'b1, lo);
    chk("read", {8'h0, exp}, {8'h0, hi, lo});
    chk("released", 24'h0, {23'h0, sda_oe});
  endtask : read2

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write();
    m.start();
    send(ADDR_W, 1'b0);
    send(8'h04, 1'b0);
    send(8'hAB, 1'b0);
    send(8'hCD, 1'b0);
    m.stop();
    pop(24'h04_ABCD);
    chk("empty", 24'h0, {23'h0, wr_valid});
    $display("test write done");
  endtask : t_write

  task automatic t_miss();
    logic [7:0] bad [2];
    bad = '{8'h38, 8'hEA};
    for (int i = 0; i < 2; i++) begin
      m.start();
      send(bad[i], 1'b1);
      m.stop();
    end
    // Moved straps must move the address that is answered
    strap = 3'h2;
    m.start();
    send(ADDR_W, 1'b1);
    m.stop();
    m.start();
    send({ADDR_FIXED, 3'h2, 1'b0}, 1'b0);
    m.stop();
    strap = 3'h5;
    $display("test address miss done");
  endtask : t_miss

  task automatic t_read_ptr();
    m.start();
    send(ADDR_W, 1'b0);
    send(8'h07, 1'b0);
    m.start();
    send(ADDR_R, 1'b0);
    read2(16'h07F8);
    m.stop();
    chk("pointer", 24'h07, {16'h0, rd_ptr});
    $display("test read with pointer done");
  endtask : t_read_ptr

  task automatic t_stall();
    m.start();
    send(ADDR_W, 1'b0);
    send(8'h01, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b0);
    send(8'h44, 1'b0);
    m.stop();
    pop(24'h01_1122);
    pop(24'h01_3344);
    chk("empty", 24'h0, {23'h0, wr_valid});
    $display("test stalled write done");
  endtask : t_stall

  task automatic t_read_keep();
    m.start();
    send(ADDR_R, 1'b0);
    read2(16'h01FE);
    m.stop();
    $display("test pointer-less read done");
  endtask : t_read_keep

  task automatic t_timeout();
    m.start();
    send(ADDR_R, 1'b0);
    m.qw();
    chk("drive", 24'h1, {23'h0, sda_oe});
    repeat (100) @(negedge clk);
    chk("timeout", 24'h0, {23'h0, sda_oe});
    m.stop();
    $display("test clock timeout done");
  endtask : t_timeout

  task automatic t_stop_tx();
    logic r;
    m.start();
    send(ADDR_W, 1'b0);
    send(8'h80, 1'b0);
    m.stop();
    repeat (10) @(negedge clk);
    chk("no word", 24'h0, {23'h0, wr_valid});
    // MSB starts with a one, so the line is free for the stop
    m.start();
    send(ADDR_R, 1'b0);
    m.stop();
    // A port still sending would pull the next bit low here
    m.xbit(1'b1, r);
    m.xbit(1'b1, r);
    chk("stop release", 24'h1, {23'h0, r});
    chk("stop idle", 24'h0, {23'h0, sda_oe});
    m.stop();
    $display("test stop while sending done");
  endtask : t_stop_tx

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (40) @(negedge clk);
    t_write();
    t_miss();
    t_read_ptr();
    t_stall();
    t_read_keep();
    t_timeout();
    t_read_keep();
    t_stop_tx();
    test_done();
  end

  // Whole run needs about 200 us; a hang ends at this cap, well above that
  initial begin
    #500000;
    err_total++;
    test_done();
  end
endmodule : testbench
